// File: src/arsl_slice.sv
// ALU register slice: eight 4-bit registers, output register, pins and an AXI4-Lite slave.
// Assumes a single clk; cycle clock, execute and output enable are slow asynchronous pins.
`timescale 1ns/1ps
`include "arsl_regs.svh"

module arsl_slice (
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire logic [`ARSL_ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic [1:0]                     s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [`ARSL_ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic [31:0]                    s_axi_rdata,
	output logic [1:0]                     s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	input  wire logic                      top_slice_select,
	input  wire logic                      execute_n,
	input  wire logic                      cycle_clock,
	input  wire logic                      output_drive_enable_n,
	input  wire logic                      carry_or_opcode_bit0,
	input  wire logic                      opcode_bit1,
	input  wire logic                      opcode_bit2,
	input  wire logic [2:0]                register_select,
	input  wire logic [3:0]                operand_in_n,
	output logic [3:0]                     data_out_n,
	output logic                           data_out_oe,
	output logic                           ripple_carry_n,
	output logic                           propagate_n,
	output logic                           generate_n,
	output logic                           zero_out,
	output logic                           zero_oe,
	output logic                           irq
);

	arsl_pkg::arsl_nib_t   ram [`ARSL_WORDS];
	arsl_pkg::arsl_nib_t   next_ram [`ARSL_WORDS];
	arsl_pkg::arsl_nib_t   operand_latch;
	arsl_pkg::arsl_nib_t   next_operand_latch;
	arsl_pkg::arsl_nib_t   result;
	arsl_pkg::arsl_flags_s flags;
	arsl_pkg::arsl_pins_s  pins;
	arsl_pkg::arsl_pins_s  next_pins;
	arsl_pkg::arsl_op_t    op;
	logic                  overflow;
	logic [`ARSL_SYNC_N-1:0] pin_raw;
	logic [`ARSL_SYNC_N-1:0] sync1;
	logic [`ARSL_SYNC_N-1:0] sync2;
	logic [`ARSL_SYNC_N-1:0] sync3;
	logic                  cc_rise;
	logic                  write_back;
	logic [3:0]            next_data_out_n;
	logic                  next_data_out_oe;
	logic [31:0]           ctrl;
	logic [31:0]           next_ctrl;
	logic [`ARSL_INT_W-1:0] int_stat;
	logic [`ARSL_INT_W-1:0] next_int_stat;
	logic [`ARSL_INT_W-1:0] int_mask;
	logic [`ARSL_INT_W-1:0] next_int_mask;
	logic [`ARSL_INT_W-1:0] int_event;
	logic                  next_irq;
	logic                  aw_held;
	logic                  next_aw_held;
	logic                  w_held;
	logic                  next_w_held;
	logic [`ARSL_ADDR_W-1:0] aw_addr;
	logic [`ARSL_ADDR_W-1:0] next_aw_addr;
	logic [31:0]           w_data;
	logic [31:0]           next_w_data;
	logic [3:0]            w_strb;
	logic [3:0]            next_w_strb;
	logic                  next_awready;
	logic                  next_wready;
	logic                  next_bvalid;
	logic [1:0]            next_bresp;
	logic                  next_arready;
	logic                  next_rvalid;
	logic [31:0]           next_rdata;
	logic [1:0]            next_rresp;
	logic                  do_write;
	logic [31:0]           wmask;
	logic [31:0]           state_word;

	assign op      = {opcode_bit2, opcode_bit1, carry_or_opcode_bit0};
	assign pin_raw = {cycle_clock, execute_n, output_drive_enable_n};

	// Combinational core; the expansion pins cannot be registered without breaking the cascade.
	arsl_alu u_alu (
		.top_slice_select (top_slice_select),
		.op               (op),
		.reg_val          (operand_latch),
		.opnd             (~operand_in_n),
		.result           (result),
		.overflow         (overflow),
		.flags            (flags)
	);

	// Expansion and zero pins follow the ALU directly, independent of execute and the clocks.
	assign ripple_carry_n = flags.ripple_n;
	assign propagate_n    = flags.prop_n;
	assign generate_n     = flags.gen_n;
	assign zero_out       = 1'b0;
	assign zero_oe        = flags.nonzero;

	// Three-stage synchronisers for the slow control pins, one per pin.
	for (genvar i = 0; i < `ARSL_SYNC_N; i++) begin : g_sync
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				sync1[i] <= 1'b1;
				sync2[i] <= 1'b1;
				sync3[i] <= 1'b1;
			end else begin
				sync1[i] <= pin_raw[i];
				sync2[i] <= sync1[i];
				sync3[i] <= sync2[i];
			end
		end
	end

	// A pin level counts only once the second and third stages agree.
	always_comb begin
		next_pins = pins;
		if (sync2[2] == sync3[2]) begin
			next_pins.cycle_clock = sync3[2];
		end
		if (sync2[1] == sync3[1]) begin
			next_pins.execute_n = sync3[1];
		end
		if (sync2[0] == sync3[0]) begin
			next_pins.drive_n = sync3[0];
		end
	end

	// Microcycle: latches follow the RAM while the cycle clock is high and hold while it is low,
	// so write-back cannot feed its own result into the adder.
	always_comb begin
		cc_rise            = next_pins.cycle_clock & ~pins.cycle_clock;
		write_back         = ~pins.cycle_clock & ~pins.execute_n & ctrl[`ARSL_CTRL_WB_BIT];
		next_operand_latch = pins.cycle_clock ? ram[register_select] : operand_latch;
		next_data_out_n    = data_out_n;
		if (cc_rise && !pins.execute_n) begin
			next_data_out_n = ~result;
		end
		next_data_out_oe   = ~next_pins.drive_n;
	end

	// One write port per RAM word.
	for (genvar w = 0; w < `ARSL_WORDS; w++) begin : g_ram
		always_comb begin
			next_ram[w] = ram[w];
			if (write_back && register_select == 3'(w)) begin
				next_ram[w] = result;
			end
		end
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				ram[w] <= 4'h0;
			end else begin
				ram[w] <= next_ram[w];
			end
		end
	end

	// Events are taken at each output-register load; a new event wins over a clear.
	always_comb begin
		int_event = '0;
		if (cc_rise && !pins.execute_n) begin
			int_event[`ARSL_INT_DONE_BIT] = 1'b1;
			int_event[`ARSL_INT_OVF_BIT]  = overflow & top_slice_select;
			int_event[`ARSL_INT_ZERO_BIT] = ~flags.nonzero;
		end
	end

	// AXI4-Lite slave: address and data are taken in either order, one write and one read at a time.
	always_comb begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_aw_addr = aw_addr;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = s_axi_bvalid;
		next_bresp   = s_axi_bresp;
		next_ctrl    = ctrl;
		next_int_mask = int_mask;
		next_int_stat = int_stat;
		wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		do_write = aw_held & w_held & ~s_axi_bvalid;
		if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = `ARSL_RESP_OKAY;
			if (aw_addr == `ARSL_CTRL_OFS) begin
				next_ctrl = (ctrl & ~wmask) | (w_data & wmask);
			end else if (aw_addr == `ARSL_INT_MASK_OFS) begin
				next_int_mask = (int_mask & ~wmask[`ARSL_INT_W-1:0])
					| (w_data[`ARSL_INT_W-1:0] & wmask[`ARSL_INT_W-1:0]);
			end else if (aw_addr == `ARSL_INT_STAT_OFS) begin
				next_int_stat = int_stat & ~(w_data[`ARSL_INT_W-1:0] & wmask[`ARSL_INT_W-1:0]);
			end else if (aw_addr != `ARSL_STATE_OFS) begin
				next_bresp = `ARSL_RESP_SLVERR;
			end
		end
		next_int_stat = next_int_stat | int_event;
		next_irq      = |(next_int_stat & next_int_mask);
		next_awready  = ~next_aw_held & ~next_bvalid;
		next_wready   = ~next_w_held & ~next_bvalid;
	end

	// Read side; the state word shows the output register, live result and slice flags.
	always_comb begin
		state_word   = {20'h0_0000, flags.ripple_n, flags.gen_n, flags.prop_n,
			~flags.nonzero, result, ~data_out_n};
		next_rvalid  = s_axi_rvalid;
		next_rdata   = s_axi_rdata;
		next_rresp   = s_axi_rresp;
		if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = `ARSL_RESP_OKAY;
			if (s_axi_araddr == `ARSL_CTRL_OFS) begin
				next_rdata = ctrl;
			end else if (s_axi_araddr == `ARSL_STATE_OFS) begin
				next_rdata = state_word;
			end else if (s_axi_araddr == `ARSL_INT_STAT_OFS) begin
				next_rdata = {29'h0, int_stat};
			end else if (s_axi_araddr == `ARSL_INT_MASK_OFS) begin
				next_rdata = {29'h0, int_mask};
			end else begin
				next_rdata = 32'h0000_0000;
				next_rresp = `ARSL_RESP_SLVERR;
			end
		end
		next_arready = ~next_rvalid;
	end

	// Registered state of the slice other than the RAM words and the synchronisers.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pins          <= '1;
			operand_latch <= 4'h0;
			data_out_n    <= 4'hF;
			data_out_oe   <= 1'b0;
			ctrl          <= `ARSL_CTRL_RST;
			int_stat      <= `ARSL_INT_RST;
			int_mask      <= `ARSL_INT_RST;
			irq           <= 1'b0;
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= '0;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `ARSL_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `ARSL_RESP_OKAY;
		end else begin
			pins          <= next_pins;
			operand_latch <= next_operand_latch;
			data_out_n    <= next_data_out_n;
			data_out_oe   <= next_data_out_oe;
			ctrl          <= next_ctrl;
			int_stat      <= next_int_stat;
			int_mask      <= next_int_mask;
			irq           <= next_irq;
			aw_held       <= next_aw_held;
			w_held        <= next_w_held;
			aw_addr       <= next_aw_addr;
			w_data        <= next_w_data;
			w_strb        <= next_w_strb;
			s_axi_awready <= next_awready;
			s_axi_wready  <= next_wready;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_arready <= next_arready;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
		end
	end

endmodule

// File: src/arsl_regs.svh
// Register offsets, field positions, reset values and opcode codes of the ALU register slice.
// Assumes a 12-bit AXI4-Lite byte address with one aligned 32-bit word per register.
`ifndef ARSL_REGS_SVH
`define ARSL_REGS_SVH

`define ARSL_ADDR_W        12
`define ARSL_CTRL_OFS      12'h000
`define ARSL_STATE_OFS     12'h004
`define ARSL_INT_STAT_OFS  12'h008
`define ARSL_INT_MASK_OFS  12'h00C

`define ARSL_CTRL_RST      32'h0000_0001
`define ARSL_CTRL_WB_BIT   0
`define ARSL_INT_W         3
`define ARSL_INT_DONE_BIT  0
`define ARSL_INT_OVF_BIT   1
`define ARSL_INT_ZERO_BIT  2
`define ARSL_INT_RST       3'h0

`define ARSL_RESP_OKAY     2'h0
`define ARSL_RESP_SLVERR   2'h2

`define ARSL_OP_ADD_INC    3'h0
`define ARSL_OP_ADD        3'h1
`define ARSL_OP_AND        3'h2
`define ARSL_OP_PASS_D     3'h3
`define ARSL_OP_PASS_R     3'h4
`define ARSL_OP_OR         3'h5
`define ARSL_OP_XOR        3'h6
`define ARSL_OP_NOT_D      3'h7

`define ARSL_WORDS         8
`define ARSL_SYNC_N        3
`define ARSL_SYNC_RST      3'h7

`endif

// File: src/arsl_pkg.sv
// Types shared by the ALU register slice and its combinational core.
// Assumes the constants of arsl_regs.svh are included where numbers are needed.
package arsl_pkg;

	typedef logic [3:0] arsl_nib_t;
	typedef logic [2:0] arsl_op_t;

	// Expansion and status outputs of one slice; the expansion flags are active low as on the pins, nonzero is active high.
	typedef struct packed {
		logic ripple_n;
		logic prop_n;
		logic gen_n;
		logic nonzero;
	} arsl_flags_s;

	// Synchronised pin levels.
	typedef struct packed {
		logic cycle_clock;
		logic execute_n;
		logic drive_n;
	} arsl_pins_s;

endpackage

// File: src/arsl_alu.sv
// Combinational 4-bit ALU and expansion control logic of one slice.
// Assumes operands are active high here; the caller inverts the active-low data bus.
`timescale 1ns/1ps
`include "arsl_regs.svh"

module arsl_alu (
	input  wire logic                 top_slice_select,
	input  wire arsl_pkg::arsl_op_t   op,
	input  wire arsl_pkg::arsl_nib_t  reg_val,
	input  wire arsl_pkg::arsl_nib_t  opnd,
	output arsl_pkg::arsl_nib_t       result,
	output logic                      overflow,
	output arsl_pkg::arsl_flags_s     flags
);

	logic                arith;
	logic                cin;
	logic [4:0]          sum;
	arsl_pkg::arsl_nib_t g;
	arsl_pkg::arsl_nib_t p;
	logic                grp_p;
	logic                grp_g;

	// Operation select; the low opcode bit doubles as the active-low carry in.
	always_comb begin
		arith = ~op[2] & ~op[1];
		cin   = ~op[0];
		sum   = {1'b0, reg_val} + {1'b0, opnd} + {4'h0, cin};
		g     = reg_val & opnd;
		p     = reg_val | opnd;
		grp_p = &p;
		grp_g = g[3] | (p[3] & g[2]) | (p[3] & p[2] & g[1]) | (p[3] & p[2] & p[1] & g[0]);
		if (arith) begin
			result = sum[3:0];
		end else if (op == `ARSL_OP_AND) begin
			result = reg_val & opnd;
		end else if (op == `ARSL_OP_PASS_D) begin
			result = opnd;
		end else if (op == `ARSL_OP_PASS_R) begin
			result = reg_val;
		end else if (op == `ARSL_OP_OR) begin
			result = reg_val | opnd;
		end else if (op == `ARSL_OP_XOR) begin
			result = reg_val ^ opnd;
		end else begin
			result = ~opnd;
		end
		overflow = arith & (reg_val[3] == opnd[3]) & (result[3] != reg_val[3]);
	end

	// Expansion outputs; no clock or execute term, so a cascade settles within one microcycle.
	always_comb begin
		flags.nonzero = |result;
		if (arith) begin
			flags.ripple_n = ~sum[4];
		end else begin
			flags.ripple_n = op[0];
		end
		if (top_slice_select) begin
			flags.prop_n = ~result[3];
			flags.gen_n  = ~overflow;
		end else if (arith) begin
			flags.prop_n = ~grp_p;
			flags.gen_n  = ~grp_g;
		end else begin
			flags.prop_n = 1'b0;
			flags.gen_n  = 1'b1;
		end
	end

endmodule

// File: dv/arsl_cascade_partner.sv
// Behavioural far side of one slice: a lookahead carry stage and the pulled-up zero line.
// Assumes the lower slice's propagate, generate, carry and zero drive come from the bench.
`timescale 1ns/1ps

module arsl_cascade_partner (
	input  wire logic low_prop_n,
	input  wire logic low_gen_n,
	input  wire logic low_carry_in_n,
	input  wire logic low_zero_oe,
	input  wire logic dut_zero_oe,
	output logic      carry_n,
	output logic      zero_line
);
	// Active-low lookahead stage; propagate low with generate high passes the carry through.
	assign carry_n = low_gen_n & (low_prop_n | low_carry_in_n);
	// Wired zero: any slice that drives pulls low, otherwise the load resistor wins.
	assign zero_line = !(low_zero_oe || dut_zero_oe);
endmodule

// File: dv/arsl_slice_properties.sv
// Concurrent checks on the expansion, status and output register pins of one slice.
// Assumes it is bound to arsl_slice and that everything runs on clk with rst as disable.
`timescale 1ns/1ps

module arsl_slice_properties (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       top_slice_select,
	input wire logic       cycle_clock,
	input wire logic       carry_or_opcode_bit0,
	input wire logic       opcode_bit1,
	input wire logic       opcode_bit2,
	input wire logic [3:0] operand_in_n,
	input wire logic [3:0] data_out_n,
	input wire logic       ripple_carry_n,
	input wire logic       propagate_n,
	input wire logic       generate_n,
	input wire logic       zero_out,
	input wire logic       zero_oe
);
	logic       arith;
	logic       pass_d;
	logic       cc_q;
	logic [3:0] age;
	logic [3:0] next_age;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Opcode classes; pass-through of the data bus makes the result visible at the pins.
	assign arith = !opcode_bit1 && !opcode_bit2;
	assign pass_d = !opcode_bit2 && opcode_bit1 && carry_or_opcode_bit0;

	// Cycles since the cycle clock pin rose; it saturates so long idle time never wraps.
	always_comb begin
		next_age = age;
		if (cycle_clock && !cc_q)
			next_age = 4'h0;
		else if (age != 4'hF)
			next_age = age + 4'h1;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			age  <= 4'hF;
			cc_q <= 1'h1;
		end else begin
			age  <= next_age;
			cc_q <= cycle_clock;
		end
	end

	property p_ripple_pass;
		!arith |-> ripple_carry_n == carry_or_opcode_bit0;
	endproperty
	a_ripple_pass: assert property (p_ripple_pass)
		else $error("ripple did not copy opcode bit");

	property p_carry_full;
		arith && operand_in_n == 4'h0 && !carry_or_opcode_bit0 |-> !ripple_carry_n;
	endproperty
	a_carry_full: assert property (p_carry_full)
		else $error("missing carry out");

	property p_carry_none;
		arith && operand_in_n == 4'hF && carry_or_opcode_bit0 |-> ripple_carry_n;
	endproperty
	a_carry_none: assert property (p_carry_none)
		else $error("spurious carry out");

	property p_lower_logic;
		!top_slice_select && !arith |-> !propagate_n && generate_n;
	endproperty
	a_lower_logic: assert property (p_lower_logic)
		else $error("lookahead pass levels wrong");

	property p_lower_gen;
		!top_slice_select && arith && operand_in_n == 4'hF |-> generate_n;
	endproperty
	a_lower_gen: assert property (p_lower_gen)
		else $error("generate without operand bits");

	property p_top_no_ovf;
		top_slice_select && !arith |-> generate_n;
	endproperty
	a_top_no_ovf: assert property (p_top_no_ovf)
		else $error("overflow on logic operation");

	property p_top_negative;
		top_slice_select && pass_d |-> propagate_n == operand_in_n[3];
	endproperty
	a_top_negative: assert property (p_top_negative)
		else $error("negative flag wrong");

	property p_zero_release;
		pass_d |-> zero_oe == (operand_in_n != 4'hF) && !zero_out;
	endproperty
	a_zero_release: assert property (p_zero_release)
		else $error("zero drive wrong");

	property p_load_timing;
		!$stable(data_out_n) |-> age != 4'h0 && age < 4'h9;
	endproperty
	a_load_timing: assert property (p_load_timing)
		else $error("output load off cycle clock");
endmodule

bind arsl_slice arsl_slice_properties arsl_slice_properties_inst (
	.clk(clk), .rst(rst), .top_slice_select(top_slice_select), .cycle_clock(cycle_clock),
	.carry_or_opcode_bit0(carry_or_opcode_bit0), .opcode_bit1(opcode_bit1),
	.opcode_bit2(opcode_bit2), .operand_in_n(operand_in_n), .data_out_n(data_out_n),
	.ripple_carry_n(ripple_carry_n), .propagate_n(propagate_n), .generate_n(generate_n),
	.zero_out(zero_out), .zero_oe(zero_oe)
);

// File: dv/arsl_slice_bench.sv
// Self-checking bench for one ALU register slice beside its cascade partner.
// Assumes the package, the register header and both design modules are compiled first.
`timescale 1ns/1ps
`include "arsl_regs.svh"

module arsl_slice_bench;
	logic        clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, top_slice_select, execute_n, cycle_clock;
	logic        output_drive_enable_n, b0, bit0, opcode_bit1, opcode_bit2, data_out_oe;
	logic        ripple_carry_n, propagate_n, generate_n, zero_out, zero_oe, irq;
	logic        use_la, la_carry_n, zero_line;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [3:0]  s_axi_wstrb, operand_in_n, data_out_n, low;
	logic [2:0]  register_select;
	int          mismatches, n_tests;

	// The low opcode bit comes from the bottom of the array or from the lookahead stage.
	assign bit0 = use_la ? la_carry_n : b0;

	// Slice under test and its far side.
	arsl_slice arsl_slice_inst (
		.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.top_slice_select(top_slice_select), .execute_n(execute_n), .cycle_clock(cycle_clock),
		.output_drive_enable_n(output_drive_enable_n), .carry_or_opcode_bit0(bit0),
		.opcode_bit1(opcode_bit1), .opcode_bit2(opcode_bit2), .register_select(register_select),
		.operand_in_n(operand_in_n), .data_out_n(data_out_n), .data_out_oe(data_out_oe),
		.ripple_carry_n(ripple_carry_n), .propagate_n(propagate_n), .generate_n(generate_n),
		.zero_out(zero_out), .zero_oe(zero_oe), .irq(irq));
	arsl_cascade_partner arsl_cascade_partner_inst (
		.low_prop_n(low[3]), .low_gen_n(low[2]), .low_carry_in_n(low[1]), .low_zero_oe(low[0]),
		.dut_zero_oe(zero_oe), .carry_n(la_carry_n), .zero_line(zero_line));

	// Every comparison goes through here so the counts stay honest.
	task automatic chk(input logic ok, input string msg);
		n_tests++;
		if (!ok) begin
			mismatches++;
			$display("ERROR %0t %s", $time, msg);
		end
	endtask

	task automatic print_verdict;
		if (mismatches == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// A handshake that never comes ends the run instead of hanging it.
	task automatic guard(input int i);
		if (i >= 50) begin
			mismatches++;
			$display("ERROR %0t handshake timeout", $time);
			print_verdict();
		end
	endtask

	// Write address and data offered together; each is dropped at the edge that takes it.
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
		int   i;
		logic aw;
		logic w;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		aw = 1'h0;
		w = 1'h0;
		for (i = 0; i < 50 && !(aw && w); i++) begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw = 1'h1;
				s_axi_awvalid <= 1'h0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w = 1'h1;
				s_axi_wvalid <= 1'h0;
			end
		end
		guard(i);
		s_axi_bready <= 1'h1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (s_axi_bvalid !== 1'h1 && i < 50);
		resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
		guard(i);
	endtask

	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
		int i;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (s_axi_arready !== 1'h1 && i < 50);
		guard(i);
		s_axi_arvalid <= 1'h0;
		s_axi_rready <= 1'h1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (s_axi_rvalid !== 1'h1 && i < 50);
		d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'h0;
		guard(i);
	endtask

	// Sets the slice pins, then lets the combinational outputs settle before sampling.
	task automatic pins(input logic t, input logic [2:0] op, input logic [3:0] d,
			input logic [2:0] s);
		@(posedge clk);
		top_slice_select <= t;
		{opcode_bit2, opcode_bit1, b0} <= op;
		operand_in_n <= ~d;
		register_select <= s;
		repeat (2) @(posedge clk);
		#1;
	endtask

	// One microcycle; each pin phase is long enough for the input synchronisers.
	task automatic ucycle(input logic x, input logic [2:0] s, input logic [2:0] op,
			input logic [3:0] d);
		pins(1'h0, op, d, s);
		@(posedge clk);
		execute_n <= x;
		repeat (5) @(posedge clk);
		cycle_clock <= 1'h0;
		repeat (6) @(posedge clk);
		cycle_clock <= 1'h1;
		repeat (8) @(posedge clk);
		execute_n <= 1'h1;
		#1;
	endtask

	task automatic t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(`ARSL_CTRL_OFS, d, r);
		chk(d === 32'h0000_0001 && r === `ARSL_RESP_OKAY, "control reset");
		axi_rd(`ARSL_INT_STAT_OFS, d, r);
		chk(d === 32'h0000_0000, "status reset");
		axi_rd(`ARSL_INT_MASK_OFS, d, r);
		chk(d === 32'h0000_0000, "mask reset");
		axi_rd(12'h010, d, r);
		chk(d === 32'h0000_0000 && r === `ARSL_RESP_SLVERR, "unmapped read");
		axi_wr(12'h010, 32'hFFFF_FFFF, r);
		chk(r === `ARSL_RESP_SLVERR, "unmapped write");
		axi_wr(`ARSL_STATE_OFS, 32'h0000_0000, r);
		chk(r === `ARSL_RESP_OKAY, "state write");
	endtask

	// Every logic code on both slice positions, with register 7 still holding zero.
	task automatic t_logic;
		logic [3:0] d;
		logic [3:0] res;
		for (int i = 0; i < 16; i++) begin
			if (i[2:1] != 2'h0) begin
				d = 4'h9 ^ i[3:0];
				res = (i[2:0] == 3'h7) ? ~d : ((i[2:0] == 3'h2 || i[2:0] == 3'h4) ? 4'h0 : d);
				pins(i[3], i[2:0], d, 3'h7);
				chk(ripple_carry_n === i[0], "ripple code");
				chk(zero_oe === (res != 4'h0), "zero drive");
				if (i[3])
					chk({propagate_n, generate_n} === {~res[3], 1'h1}, "top out");
				else
					chk({propagate_n, generate_n} === 2'h1, "lower flags");
			end
		end
	endtask

	// Sums on zero: {top, carry bit, data, ripple, zero drive, propagate, generate}.
	task automatic t_arith;
		logic [9:0] tab [7] = '{10'h0F1, 10'h1FD, 10'h00F, 10'h27C, 10'h37F, 10'h2F3, 10'h10B};
		foreach (tab[k]) begin
			pins(tab[k][9], {2'h0, tab[k][8]}, tab[k][7:4], 3'h7);
			chk({ripple_carry_n, zero_oe, propagate_n, generate_n} === tab[k][3:0],
				"sum flags");
		end
	endtask

	// Lower slice seen through the lookahead stage and the shared zero wire.
	task automatic t_cascade;
		@(posedge clk);
		use_la <= 1'h1;
		for (int c = 0; c < 2; c++) begin
			// Lower slice passes (propagate low, generate high), so its carry in reaches us.
			low <= {2'h1, c[0], 1'h0};
			pins(1'h0, 3'h2, 4'h6, 3'h7);
			chk(ripple_carry_n === c[0], "opcode bit through lookahead");
		end
		low <= 4'h0;
		pins(1'h0, 3'h0, 4'hF, 3'h7);
		chk(ripple_carry_n === 1'h0 && zero_line === 1'h1, "lookahead carry in");
		// Neither propagate nor generate below: no carry in, and the lower slice pulls zero low.
		low <= 4'hD;
		pins(1'h0, 3'h0, 4'hF, 3'h7);
		chk(ripple_carry_n === 1'h1 && zero_line === 1'h0, "no carry, wired zero");
		use_la <= 1'h0;
	endtask

	// Loads, write-back, refusal with execute high, and the done interrupt.
	task automatic t_cycle;
		logic [31:0] d;
		logic [1:0]  r;
		@(posedge clk);
		output_drive_enable_n <= 1'h0;
		axi_wr(`ARSL_INT_MASK_OFS, 32'h0000_0001, r);
		ucycle(1'h0, 3'h1, 3'h3, 4'h5);
		chk(data_out_n === 4'hA && data_out_oe === 1'h1 && irq === 1'h1, "load");
		axi_rd(`ARSL_INT_STAT_OFS, d, r);
		chk(d === 32'h0000_0001, "done status");
		axi_wr(`ARSL_INT_STAT_OFS, 32'h0000_0001, r);
		@(posedge clk);
		#1;
		chk(irq === 1'h0, "interrupt clear");
		axi_wr(`ARSL_INT_MASK_OFS, 32'h0000_0000, r);
		ucycle(1'h0, 3'h2, 3'h4, 4'h0);
		chk(data_out_n === 4'hF && irq === 1'h0, "masked zero load");
		axi_rd(`ARSL_INT_STAT_OFS, d, r);
		chk(d === 32'h0000_0005, "done and zero status");
		ucycle(1'h1, 3'h1, 3'h3, 4'h3);
		chk(data_out_n === 4'hF, "load while execute high");
		pins(1'h0, 3'h4, 4'h0, 3'h1);
		axi_rd(`ARSL_STATE_OFS, d, r);
		chk(d[7:0] === 8'h50, "written back register");
		// With write-back off the output register still loads but register 1 keeps its value.
		axi_wr(`ARSL_CTRL_OFS, 32'h0000_0000, r);
		ucycle(1'h0, 3'h1, 3'h3, 4'hC);
		pins(1'h0, 3'h4, 4'h0, 3'h1);
		axi_rd(`ARSL_STATE_OFS, d, r);
		chk(d[7:0] === 8'h5C, "load without write-back");
	endtask

	// Free-running 40 MHz clock.
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end

	// Reset, then each scenario in turn.
	initial begin
		rst = 1'h1;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready, top_slice_select, b0, use_la} = '0;
		{opcode_bit1, opcode_bit2, register_select, operand_in_n, low} = '0;
		{execute_n, cycle_clock, output_drive_enable_n} = 3'h7;
		mismatches = 0;
		n_tests = 0;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		t_regs();
		t_logic();
		t_arith();
		t_cascade();
		t_cycle();
		print_verdict();
	end
endmodule
